// ==== ppr_params.svh ====
// Offsets, field positions and reset values of the peripheral priority registers
`ifndef PPR_PARAMS_SVH
`define PPR_PARAMS_SVH
`define PPR_SELECT_1_OFFSET   12'h000
`define PPR_SELECT_2_OFFSET   12'h004
`define PPR_SELECT_1_RESET    8'hFF
`define PPR_SELECT_2_RESET    8'h0F
`define PPR_SELECT_2_IMPL     8'h0F
`define PPR_PARALLEL_BIT      7
`define PPR_CONVERTER_BIT     6
`define PPR_SER_RX_BIT        5
`define PPR_SER_TX_BIT        4
`define PPR_SYNC_SERIAL_BIT   3
`define PPR_CAPTURE_ONE_BIT   2
`define PPR_TIMER_TWO_BIT     1
`define PPR_TIMER_ONE_BIT     0
`define PPR_BUS_COLL_BIT      3
`define PPR_LOW_VOLT_BIT      2
`define PPR_TIMER_THREE_BIT   1
`define PPR_CAPTURE_TWO_BIT   0
`endif

// ==== ppr_pkg.sv ====
// Types shared by the peripheral priority register block
package ppr_pkg;
  typedef logic [7:0]  ppr_byte_t;
  typedef logic [11:0] ppr_addr_t;
  typedef logic [31:0] ppr_word_t;
endpackage

// ==== ppr_top.sv ====
// Peripheral interrupt priority select registers behind an APB slave
// Function
// - Bit one means high, zero low priority
// - First register bit 7: parallel port
// - First register bit 3: sync serial port
// - Second register bit 2: low-voltage detect
// - Second register bit 1: third timer overflow
// - Second register bit 0: second capture unit
// - Second register bits 7-4 read zero
// - All implemented bits reset to one
`timescale 1ns/1ps
`default_nettype none
`include "ppr_params.svh"
module ppr_top (
  input  wire logic              MCLK_I,
  input  wire logic              RST_N_I,
  input  wire logic              PSEL_I,
  input  wire logic              PENABLE_I,
  input  wire logic              PWRITE_I,
  input  wire ppr_pkg::ppr_addr_t PADDR_I,
  input  wire ppr_pkg::ppr_word_t PWDATA_I,
  input  wire logic [3:0]        PSTRB_I,
  output logic                   PREADY_O,
  output logic                   PSLVERR_O,
  output ppr_pkg::ppr_word_t     PRDATA_O,
  output logic                   PARALLEL_PORT_PRIO_O,
  output logic                   CONVERTER_PRIO_O,
  output logic                   SERIAL_RECEIVE_PRIO_O,
  output logic                   SERIAL_TRANSMIT_PRIO_O,
  output logic                   SYNC_SERIAL_PRIO_O,
  output logic                   CAPTURE_UNIT_ONE_PRIO_O,
  output logic                   TIMER_TWO_MATCH_PRIO_O,
  output logic                   TIMER_ONE_OVERFLOW_PRIO_O,
  output logic                   BUS_COLLISION_PRIO_O,
  output logic                   LOW_VOLTAGE_DETECT_PRIO_O,
  output logic                   TIMER_THREE_OVERFLOW_PRIO_O,
  output logic                   CAPTURE_UNIT_TWO_PRIO_O
);
  import ppr_pkg::*;

  ppr_byte_t prio_sel_1_ff;
  ppr_byte_t prio_sel_2_ff;
  ppr_word_t rdata_ff;
  ppr_byte_t nxt_prio_sel_1;
  ppr_byte_t nxt_prio_sel_2;
  ppr_word_t nxt_rdata;
  logic      access;
  logic      hit_1;
  logic      hit_2;

  // Decode uses bits above the word index too, so aliases do not exist
  function automatic logic addr_hit(input ppr_addr_t a, input ppr_addr_t off);
    addr_hit = (a[11:2] == off[11:2]);
  endfunction

  // Single-cycle access: every transfer completes in its first access cycle
  assign PREADY_O  = 1'b1;
  assign access    = PSEL_I && PENABLE_I;
  assign hit_1     = addr_hit(PADDR_I, `PPR_SELECT_1_OFFSET);
  assign hit_2     = addr_hit(PADDR_I, `PPR_SELECT_2_OFFSET);

  always_comb begin
    nxt_prio_sel_1 = prio_sel_1_ff;
    nxt_prio_sel_2 = prio_sel_2_ff;
    nxt_rdata      = rdata_ff;
    if (access && PWRITE_I && PSTRB_I[0]) begin
      if (hit_1) begin
        nxt_prio_sel_1 = PWDATA_I[7:0];
      end
      if (hit_2) begin
        nxt_prio_sel_2 = PWDATA_I[7:0] & `PPR_SELECT_2_IMPL;
      end
    end
    if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
      nxt_rdata = 32'h0000_0000;
      if (hit_1) begin
        nxt_rdata = {24'h00_0000, prio_sel_1_ff};
      end
      if (hit_2) begin
        nxt_rdata = {24'h00_0000, prio_sel_2_ff & `PPR_SELECT_2_IMPL};
      end
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      prio_sel_1_ff <= `PPR_SELECT_1_RESET;
      prio_sel_2_ff <= `PPR_SELECT_2_RESET;
      rdata_ff      <= 32'h0000_0000;
    end else begin
      prio_sel_1_ff <= nxt_prio_sel_1;
      prio_sel_2_ff <= nxt_prio_sel_2;
      rdata_ff      <= nxt_rdata;
    end
  end

  assign PRDATA_O  = rdata_ff;
  // Unmapped address answers with an error in its access cycle, registers untouched
  assign PSLVERR_O = access && !hit_1 && !hit_2;

  assign PARALLEL_PORT_PRIO_O        = prio_sel_1_ff[`PPR_PARALLEL_BIT];
  assign CONVERTER_PRIO_O            = prio_sel_1_ff[`PPR_CONVERTER_BIT];
  assign SERIAL_RECEIVE_PRIO_O       = prio_sel_1_ff[`PPR_SER_RX_BIT];
  assign SERIAL_TRANSMIT_PRIO_O      = prio_sel_1_ff[`PPR_SER_TX_BIT];
  assign SYNC_SERIAL_PRIO_O          = prio_sel_1_ff[`PPR_SYNC_SERIAL_BIT];
  assign CAPTURE_UNIT_ONE_PRIO_O     = prio_sel_1_ff[`PPR_CAPTURE_ONE_BIT];
  assign TIMER_TWO_MATCH_PRIO_O      = prio_sel_1_ff[`PPR_TIMER_TWO_BIT];
  assign TIMER_ONE_OVERFLOW_PRIO_O   = prio_sel_1_ff[`PPR_TIMER_ONE_BIT];
  assign BUS_COLLISION_PRIO_O        = prio_sel_2_ff[`PPR_BUS_COLL_BIT];
  assign LOW_VOLTAGE_DETECT_PRIO_O   = prio_sel_2_ff[`PPR_LOW_VOLT_BIT];
  assign TIMER_THREE_OVERFLOW_PRIO_O = prio_sel_2_ff[`PPR_TIMER_THREE_BIT];
  assign CAPTURE_UNIT_TWO_PRIO_O     = prio_sel_2_ff[`PPR_CAPTURE_TWO_BIT];

  property p_write_one;
    @(posedge MCLK_I) disable iff (!RST_N_I)
      (PSEL_I && PENABLE_I && PWRITE_I && PSTRB_I[0] && hit_1)
      |=> (prio_sel_1_ff == $past(PWDATA_I[7:0]));
  endproperty
  a_write_one: assert property (p_write_one) else $error("select 1 write lost");

  property p_parallel;
    @(posedge MCLK_I) disable iff (!RST_N_I)
      (PSEL_I && PENABLE_I && PWRITE_I && PSTRB_I[0] && hit_1)
      |=> (PARALLEL_PORT_PRIO_O == $past(PWDATA_I[7]));
  endproperty
  a_parallel: assert property (p_parallel) else $error("parallel bit wrong");

  property p_sync;
    @(posedge MCLK_I) disable iff (!RST_N_I)
      (PSEL_I && PENABLE_I && PWRITE_I && PSTRB_I[0] && hit_1)
      |=> (SYNC_SERIAL_PRIO_O == $past(PWDATA_I[3]));
  endproperty
  a_sync: assert property (p_sync) else $error("sync serial bit wrong");

  property p_lowv;
    @(posedge MCLK_I) disable iff (!RST_N_I)
      (PSEL_I && PENABLE_I && PWRITE_I && PSTRB_I[0] && hit_2)
      |=> (LOW_VOLTAGE_DETECT_PRIO_O == $past(PWDATA_I[2]));
  endproperty
  a_lowv: assert property (p_lowv) else $error("low voltage bit wrong");

  property p_third_timer;
    @(posedge MCLK_I) disable iff (!RST_N_I)
      (PSEL_I && PENABLE_I && PWRITE_I && PSTRB_I[0] && hit_2)
      |=> (TIMER_THREE_OVERFLOW_PRIO_O == $past(PWDATA_I[1]));
  endproperty
  a_third_timer: assert property (p_third_timer) else $error("third timer bit wrong");

  property p_cap2;
    @(posedge MCLK_I) disable iff (!RST_N_I)
      (PSEL_I && PENABLE_I && PWRITE_I && PSTRB_I[0] && hit_2)
      |=> (CAPTURE_UNIT_TWO_PRIO_O == $past(PWDATA_I[0]));
  endproperty
  a_cap2: assert property (p_cap2) else $error("second capture bit wrong");

  property p_upper_zero;
    @(posedge MCLK_I) disable iff (!RST_N_I)
      (PSEL_I && !PENABLE_I && !PWRITE_I && hit_2) |=> (PRDATA_O[31:4] == 28'h0000000);
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper bits not zero");

  property p_busc;
    @(posedge MCLK_I) disable iff (!RST_N_I)
      (PSEL_I && PENABLE_I && PWRITE_I && PSTRB_I[0] && hit_2)
      |=> (BUS_COLLISION_PRIO_O == $past(PWDATA_I[3]));
  endproperty
  a_busc: assert property (p_busc) else $error("bus collision bit wrong");

  property p_reset;
    @(posedge MCLK_I) !RST_N_I |=> (prio_sel_1_ff == `PPR_SELECT_1_RESET) &&
      (prio_sel_2_ff == `PPR_SELECT_2_RESET);
  endproperty
  a_reset: assert property (p_reset) else $error("reset value wrong");

  sequence s_write_1;
    PSEL_I && PENABLE_I && PWRITE_I && PSTRB_I[0] && hit_1;
  endsequence

  sequence s_write_2;
    PSEL_I && PENABLE_I && PWRITE_I && PSTRB_I[0] && hit_2;
  endsequence

  sequence s_read_setup_1;
    PSEL_I && !PENABLE_I && !PWRITE_I && hit_1;
  endsequence

  sequence s_read_setup_2;
    PSEL_I && !PENABLE_I && !PWRITE_I && hit_2;
  endsequence

  sequence s_read_1;
    s_read_setup_1 ##1 (PSEL_I && PENABLE_I);
  endsequence

  sequence s_read_2;
    s_read_setup_2 ##1 (PSEL_I && PENABLE_I);
  endsequence

  sequence s_masked_write;
    PSEL_I && PENABLE_I && PWRITE_I && !PSTRB_I[0];
  endsequence

  sequence s_unmapped_access;
    PSEL_I && PENABLE_I && !hit_1 && !hit_2;
  endsequence

  sequence s_no_write;
    !(PSEL_I && PENABLE_I && PWRITE_I);
  endsequence

  property p_conv;
    @(posedge MCLK_I) disable iff (!RST_N_I)
      s_write_1 |=> (CONVERTER_PRIO_O == $past(PWDATA_I[`PPR_CONVERTER_BIT]));
  endproperty
  a_conv: assert property (p_conv) else $error("converter bit wrong");

  property p_ser_rx;
    @(posedge MCLK_I) disable iff (!RST_N_I)
      s_write_1 |=> (SERIAL_RECEIVE_PRIO_O == $past(PWDATA_I[`PPR_SER_RX_BIT]));
  endproperty
  a_ser_rx: assert property (p_ser_rx) else $error("serial receive bit wrong");

  property p_ser_tx;
    @(posedge MCLK_I) disable iff (!RST_N_I)
      s_write_1 |=> (SERIAL_TRANSMIT_PRIO_O == $past(PWDATA_I[`PPR_SER_TX_BIT]));
  endproperty
  a_ser_tx: assert property (p_ser_tx) else $error("serial transmit bit wrong");

  property p_cap1;
    @(posedge MCLK_I) disable iff (!RST_N_I)
      s_write_1 |=> (CAPTURE_UNIT_ONE_PRIO_O == $past(PWDATA_I[`PPR_CAPTURE_ONE_BIT]));
  endproperty
  a_cap1: assert property (p_cap1) else $error("first capture bit wrong");

  property p_tmr2;
    @(posedge MCLK_I) disable iff (!RST_N_I)
      s_write_1 |=> (TIMER_TWO_MATCH_PRIO_O == $past(PWDATA_I[`PPR_TIMER_TWO_BIT]));
  endproperty
  a_tmr2: assert property (p_tmr2) else $error("second timer bit wrong");

  property p_tmr1;
    @(posedge MCLK_I) disable iff (!RST_N_I)
      s_write_1 |=> (TIMER_ONE_OVERFLOW_PRIO_O == $past(PWDATA_I[`PPR_TIMER_ONE_BIT]));
  endproperty
  a_tmr1: assert property (p_tmr1) else $error("first timer bit wrong");

  property p_write_two;
    @(posedge MCLK_I) disable iff (!RST_N_I)
      s_write_2 |=> (prio_sel_2_ff == ($past(PWDATA_I[7:0]) & `PPR_SELECT_2_IMPL));
  endproperty
  a_write_two: assert property (p_write_two) else $error("select 2 write wrong");

  property p_read_1;
    @(posedge MCLK_I) disable iff (!RST_N_I)
      s_read_1 |-> (PRDATA_O == {24'h00_0000, $past(prio_sel_1_ff)});
  endproperty
  a_read_1: assert property (p_read_1) else $error("select 1 read wrong");

  property p_read_2;
    @(posedge MCLK_I) disable iff (!RST_N_I)
      s_read_2 |-> (PRDATA_O == {28'h000_0000, $past(prio_sel_2_ff[3:0])});
  endproperty
  a_read_2: assert property (p_read_2) else $error("select 2 read wrong");

  property p_sel2_upper;
    @(posedge MCLK_I) disable iff (!RST_N_I)
      (prio_sel_2_ff[7:4] == 4'h0);
  endproperty
  a_sel2_upper: assert property (p_sel2_upper) else $error("select 2 upper set");

  property p_masked_keep;
    @(posedge MCLK_I) disable iff (!RST_N_I)
      s_masked_write |=> $stable(prio_sel_1_ff) && $stable(prio_sel_2_ff);
  endproperty
  a_masked_keep: assert property (p_masked_keep) else $error("masked write landed");

  property p_unmapped_keep;
    @(posedge MCLK_I) disable iff (!RST_N_I)
      s_unmapped_access |=> $stable(prio_sel_1_ff) && $stable(prio_sel_2_ff);
  endproperty
  a_unmapped_keep: assert property (p_unmapped_keep) else $error("unmapped write landed");

  property p_idle_hold;
    @(posedge MCLK_I) disable iff (!RST_N_I)
      s_no_write |=> $stable(prio_sel_1_ff) && $stable(prio_sel_2_ff);
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("levels moved without write");

  property p_reset_outputs;
    @(posedge MCLK_I) !RST_N_I |=>
      ({PARALLEL_PORT_PRIO_O, CONVERTER_PRIO_O, SERIAL_RECEIVE_PRIO_O, SERIAL_TRANSMIT_PRIO_O,
        SYNC_SERIAL_PRIO_O, CAPTURE_UNIT_ONE_PRIO_O, TIMER_TWO_MATCH_PRIO_O,
        TIMER_ONE_OVERFLOW_PRIO_O, BUS_COLLISION_PRIO_O, LOW_VOLTAGE_DETECT_PRIO_O,
        TIMER_THREE_OVERFLOW_PRIO_O, CAPTURE_UNIT_TWO_PRIO_O} == 12'hFFF);
  endproperty
  a_reset_outputs: assert property (p_reset_outputs) else $error("reset level wrong");
endmodule
`default_nettype wire

// ==== ppr_tb.sv ====
// Self-checking testbench for the peripheral priority registers
`timescale 1ns/1ps
`default_nettype none
`include "ppr_params.svh"
module testbench;
  import ppr_pkg::*;
  logic       mclk = 1'b0;
  logic       rst_n = 1'b0;
  logic       psel = 1'b0;
  logic       penable = 1'b0;
  logic       pwrite = 1'b0;
  ppr_addr_t  paddr = '0;
  ppr_word_t  pwdata = '0;
  logic [3:0] pstrb = 4'hF;
  logic       pready;
  logic       pslverr;
  ppr_word_t  prdata;
  wire  [7:0] p1;
  wire  [3:0] p2;
  ppr_word_t  rd;
  logic       er;
  int         failures = 0;
  int         samples_checked = 0;
  always #25 mclk = ~mclk;
  ppr_top u_ppr_top (
    .MCLK_I(mclk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(pstrb),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .PRDATA_O(prdata),
    .PARALLEL_PORT_PRIO_O(p1[7]), .CONVERTER_PRIO_O(p1[6]),
    .SERIAL_RECEIVE_PRIO_O(p1[5]), .SERIAL_TRANSMIT_PRIO_O(p1[4]),
    .SYNC_SERIAL_PRIO_O(p1[3]), .CAPTURE_UNIT_ONE_PRIO_O(p1[2]),
    .TIMER_TWO_MATCH_PRIO_O(p1[1]), .TIMER_ONE_OVERFLOW_PRIO_O(p1[0]),
    .BUS_COLLISION_PRIO_O(p2[3]), .LOW_VOLTAGE_DETECT_PRIO_O(p2[2]),
    .TIMER_THREE_OVERFLOW_PRIO_O(p2[1]), .CAPTURE_UNIT_TWO_PRIO_O(p2[0]));
  task automatic chk(input string what, input ppr_word_t seen, input ppr_word_t exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One APB transfer; idles one cycle after so strobes never toggle twice in a step
  task automatic apb(input logic wr, input ppr_addr_t a, input ppr_word_t d,
                     input logic [3:0] s);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    // Strobes stay low on reads
    pstrb   <= wr ? s : 4'h0;
    @(posedge mclk);
    penable <= 1'b1;
    // Waits as long as the slave needs; only the watchdog ends a hang
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic t_reset();
    chk("rdata reset", prdata, 32'h0000_0000);
    chk("ready reset", {31'h0, pready}, 32'h0000_0001);
    chk("err reset", {31'h0, pslverr}, 32'h0000_0000);
    apb(1'b0, `PPR_SELECT_1_OFFSET, '0, 4'hF);
    chk("sel1 reset", rd, 32'h0000_00FF);
    apb(1'b0, `PPR_SELECT_2_OFFSET, '0, 4'hF);
    chk("sel2 reset", rd, 32'h0000_000F);
    chk("prio reset", {20'h0, p1, p2}, 32'h0000_0FFF);
    $display("t_reset done");
  endtask
  // Walking one proves each bit drives only its own source
  task automatic t_sel1();
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, `PPR_SELECT_1_OFFSET, 32'hFFFF_FF00 | (32'h1 << i), 4'hF);
      chk("sel1 outputs", {24'h0, p1}, 32'h1 << i);
      chk("sel2 kept", {28'h0, p2}, 32'h0000_000F);
      apb(1'b0, `PPR_SELECT_1_OFFSET, '0, 4'hF);
      chk("sel1 read", rd, 32'h1 << i);
    end
    $display("t_sel1 done");
  endtask
  task automatic t_sel2();
    apb(1'b1, `PPR_SELECT_2_OFFSET, 32'hFFFF_FFF0, 4'hF);
    apb(1'b0, `PPR_SELECT_2_OFFSET, '0, 4'hF);
    chk("sel2 upper", rd, 32'h0000_0000);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, `PPR_SELECT_2_OFFSET, 32'h0000_00F0 | (32'h1 << i), 4'hF);
      chk("sel2 outputs", {28'h0, p2}, 32'h1 << i);
      apb(1'b0, `PPR_SELECT_2_OFFSET, '0, 4'hF);
      chk("sel2 read", rd, 32'h1 << i);
    end
    $display("t_sel2 done");
  endtask
  task automatic t_refuse();
    apb(1'b1, `PPR_SELECT_1_OFFSET, 32'h0000_0000, 4'h0);
    chk("strobe off", {24'h0, p1}, 32'h0000_0080);
    apb(1'b1, 12'h008, 32'h0000_0000, 4'hF);
    chk("unmapped write", {24'h0, p1}, 32'h0000_0080);
    chk("unmapped write err", {31'h0, er}, 32'h1);
    apb(1'b0, 12'h008, '0, 4'hF);
    chk("unmapped read", rd, 32'h0);
    apb(1'b0, `PPR_SELECT_1_OFFSET, '0, 4'hF);
    chk("mapped err", {31'h0, er}, 32'h0);
    chk("mapped read", rd, 32'h0000_0080);
    $display("t_refuse done");
  endtask
  // Mid-run reset must bring every source back to high priority
  task automatic t_rereset();
    apb(1'b1, `PPR_SELECT_1_OFFSET, 32'h0000_0000, 4'hF);
    apb(1'b1, `PPR_SELECT_2_OFFSET, 32'h0000_0000, 4'hF);
    chk("prio cleared", {20'h0, p1, p2}, 32'h0000_0000);
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    chk("prio rereset", {20'h0, p1, p2}, 32'h0000_0FFF);
    apb(1'b0, `PPR_SELECT_2_OFFSET, '0, 4'hF);
    chk("sel2 rereset", rd, 32'h0000_000F);
    $display("t_rereset done");
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    t_reset();
    t_sel1();
    t_sel2();
    t_refuse();
    t_rereset();
    test_done();
  end
  // Whole run is about 110 cycles; this bound is generous
  initial begin
    #100000;
    failures++;
    test_done();
  end
endmodule
`default_nettype wire
